/* File: design/video_common_defs.svh */
/*
  Offsets, storage slots, write masks, reset values and field positions
  of the common video decoder control registers.
  Assumes it is included by bare name before any module that uses it.
*/
`ifndef VIDEO_COMMON_DEFS_SVH
`define VIDEO_COMMON_DEFS_SVH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define OFS_CLK_GAIN_A 8'h41
`define OFS_GAIN_B 8'h42
`define OFS_SYNC_CTRL 8'h45
`define OFS_GAIN_LOOP 8'h46
`define OFS_MGAIN_CH1 8'h47
`define OFS_MGAIN_CH2 8'h48
`define OFS_MGAIN_CH3 8'h49
`define OFS_MGAIN_CH4 8'h4a
`define OFS_REF_FILTER 8'h4b
`define OFS_POWER_DOWN 8'h4c
`define OFS_NOVIDEO 8'h4d
`define OFS_FREERUN 8'h4f
`define OFS_PEAK_CH12 8'h50
`define OFS_PEAK_CH34 8'h51
`define OFS_CLAMP_TEST 8'h52
`define OFS_STATUS 8'h55
`define OFS_ANA_TEST 8'h56
`define OFS_CORING_SW 8'h57

// --------------------------------------------------------------
// Storage slots of the writable registers
// --------------------------------------------------------------
`define NUM_SLOTS 17
`define SLOT_NONE 5'h1f
`define SLOT_CLK_GAIN_A 5'h00
`define SLOT_GAIN_B 5'h01
`define SLOT_SYNC_CTRL 5'h02
`define SLOT_GAIN_LOOP 5'h03
`define SLOT_MGAIN_CH1 5'h04
`define SLOT_REF_FILTER 5'h08
`define SLOT_POWER_DOWN 5'h09
`define SLOT_NOVIDEO 5'h0a
`define SLOT_FREERUN 5'h0b
`define SLOT_PEAK_CH12 5'h0c
`define SLOT_PEAK_CH34 5'h0d
`define SLOT_CLAMP_TEST 5'h0e
`define SLOT_ANA_TEST 5'h0f
`define SLOT_CORING_SW 5'h10

// --------------------------------------------------------------
// Write masks and reset values
// --------------------------------------------------------------
`define MASK_CLK_GAIN_A 8'hf7
`define MASK_GAIN_B 8'h07
`define MASK_REF_FILTER 8'h63
`define MASK_POWER_DOWN 8'h3f
`define MASK_NOVIDEO 8'h0f
`define MASK_CLAMP_TEST 8'hdf
`define MASK_FULL 8'hff
`define RST_CLK_GAIN_A 8'h77
`define RST_GAIN_B 8'h07
`define RST_SYNC_CTRL 8'hd1
`define RST_GAIN_LOOP 8'h00
`define RST_MGAIN_LOW 8'hf0
`define RST_REF_FILTER 8'h02
`define RST_POWER_DOWN 8'h00
`define RST_NOVIDEO 8'h0f
`define RST_FREERUN 8'h05
`define RST_ZERO 8'h00
`define RST_CORING_SW 8'h30

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define BIT_PIXCLK_OE 7
`define BIT_VS_ALIGN 5
`define BIT_FIELD_POL 4
`define BIT_HS_POL 3
`define BIT_VS_POL 2
`define BIT_ADC_ADC_CURRENT_REF_BOOST 6
`define BIT_ADC_VREF 5
`define BIT_ANTIALIAS 1
`define BIT_REDUCED_PWR 0
`define BIT_AUDIO_DAC_POWERDOWN 5
`define BIT_AUDIO_ADC_POWERDOWN 4
`define BIT_CLAMP_DEBUG 7
`define BIT_LUMA_CLAMP_OFF 6
`define BIT_AUDIO_AA 4
`define BIT_GAIN_TEST 3
`define BIT_CLAMP_FILTER 2
`define BIT_CLAMP_CUR1 1
`define BIT_CLAMP_CUR2 0

`endif

/* File: design/video_common_pkg.sv */
/*
  Types shared by the common video decoder control block.
  Assumes nothing of its surroundings.
*/
package video_common_pkg;

  typedef logic [7:0] byte_type;
  typedef logic [4:0] slot_type;
  typedef logic [8:0] gain_type;

  // Source of the vertical sync and field flag timing.
  typedef enum logic {ALIGN_VSYNC, ALIGN_HSYNC} vsync_align_type;

endpackage : video_common_pkg

/* File: design/sync_out_shaper.sv */
/*
  Shapes the sync and field flag outputs: polarity and timing source.
  Assumes sync inputs are active high and synchronous to core_clk.
*/
`timescale 1ns/10ps
module sync_out_shaper (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic vsync_align_sel,
  input wire logic field_flag_polarity,
  input wire logic hsync_out_polarity,
  input wire logic vsync_out_polarity,
  input wire logic hs_in,
  input wire logic vs_in,
  input wire logic odd_field_in,
  output logic hsync_out,
  output logic vsync_out,
  output logic field_flag_out
);

  logic hs_prev_reg;
  logic vs_hold_reg;
  logic odd_hold_reg;
  logic vs_sel;
  logic odd_sel;
  logic hs_rise;

  // Leading edge of horizontal sync.
  assign hs_rise = hs_in & ~hs_prev_reg;

  // Vertical sync and field are resampled at line start in hs mode.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hs_prev_reg <= 1'b0;
      vs_hold_reg <= 1'b0;
      odd_hold_reg <= 1'b0;
    end else begin
      hs_prev_reg <= hs_in;
      if (hs_rise) begin
        vs_hold_reg <= vs_in;
        odd_hold_reg <= odd_field_in;
      end
    end
  end

  // Timing source selection.
  always_comb begin
    if (vsync_align_sel == video_common_pkg::ALIGN_HSYNC) begin
      vs_sel = vs_hold_reg;
      odd_sel = odd_hold_reg;
    end else begin
      vs_sel = vs_in;
      odd_sel = odd_field_in;
    end
  end

  // Registered outputs with selectable active level.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hsync_out <= 1'b1;
      vsync_out <= 1'b1;
      field_flag_out <= 1'b0;
    end else begin
      hsync_out <= ~(hs_in ^ hsync_out_polarity);
      vsync_out <= ~(vs_sel ^ vsync_out_polarity);
      field_flag_out <= odd_sel ^ field_flag_polarity;
    end
  end

endmodule : sync_out_shaper

/* File: design/video_decoder_common_ctrl_regs.sv */
/*
  Common control and status registers of the four video decoder
  channels, with the sync output shaper and manual gain selection.
  Assumes a simple register port driven on core_clk, with one-cycle
  strobes that never overlap, and status inputs synchronous to it.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "video_common_defs.svh"

module video_decoder_common_ctrl_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic pixclk_out_enable,
  output logic [2:0] dac_output_gain_cx,
  output logic [2:0] dac_output_gain_yx,
  output logic [2:0] dac_output_gain_yy,
  input wire logic hs_in,
  input wire logic vs_in,
  input wire logic odd_field_in,
  output logic hsync_out,
  output logic vsync_out,
  output logic field_flag_out,
  output logic [3:0] auto_gain_loop_off,
  output logic [35:0] manual_gain_value,
  input wire logic [35:0] auto_gain_in,
  output logic [35:0] applied_gain,
  output logic adc_current_ref_boost,
  output logic video_vref_shutdown,
  output logic video_antialias_en,
  output logic video_reduced_power,
  output logic audio_dac_powerdown,
  output logic audio_adc_powerdown,
  output logic [3:0] video_adc_powerdown,
  output logic [1:0] novideo_flag_speed,
  output logic [1:0] freerun_rate,
  output logic [1:0] luma_noise_reduction,
  output logic [1:0] clamp_mode,
  output logic [1:0] slice_level,
  output logic [15:0] peaking_test_field,
  output logic clamp_debug,
  output logic luma_clamp_off,
  output logic audio_antialias_en,
  output logic gain_test,
  output logic clamp_filter_ctrl,
  output logic clamp_current_one,
  output logic clamp_current_two,
  output logic [7:0] analog_channel_test,
  output logic [3:0] sharpness_coring,
  output logic [3:0] input_a_b_select,
  input wire logic [3:0] ch_odd_field,
  input wire logic [3:0] ch_vactive
);

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------

  // Maps a register offset to its storage slot, or none.
  function automatic video_common_pkg::slot_type slot_of(
    input logic [7:0] addr
  );
    begin
      case (addr)
        `OFS_CLK_GAIN_A: slot_of = `SLOT_CLK_GAIN_A;
        `OFS_GAIN_B: slot_of = `SLOT_GAIN_B;
        `OFS_SYNC_CTRL: slot_of = `SLOT_SYNC_CTRL;
        `OFS_GAIN_LOOP: slot_of = `SLOT_GAIN_LOOP;
        `OFS_MGAIN_CH1: slot_of = `SLOT_MGAIN_CH1;
        `OFS_MGAIN_CH2: slot_of = 5'h05;
        `OFS_MGAIN_CH3: slot_of = 5'h06;
        `OFS_MGAIN_CH4: slot_of = 5'h07;
        `OFS_REF_FILTER: slot_of = `SLOT_REF_FILTER;
        `OFS_POWER_DOWN: slot_of = `SLOT_POWER_DOWN;
        `OFS_NOVIDEO: slot_of = `SLOT_NOVIDEO;
        `OFS_FREERUN: slot_of = `SLOT_FREERUN;
        `OFS_PEAK_CH12: slot_of = `SLOT_PEAK_CH12;
        `OFS_PEAK_CH34: slot_of = `SLOT_PEAK_CH34;
        `OFS_CLAMP_TEST: slot_of = `SLOT_CLAMP_TEST;
        `OFS_ANA_TEST: slot_of = `SLOT_ANA_TEST;
        `OFS_CORING_SW: slot_of = `SLOT_CORING_SW;
        default: slot_of = `SLOT_NONE;
      endcase
    end
  endfunction : slot_of

  // Bits of a slot that software may change; the rest stay zero.
  function automatic video_common_pkg::byte_type mask_of(
    input video_common_pkg::slot_type slot
  );
    begin
      case (slot)
        `SLOT_CLK_GAIN_A: mask_of = `MASK_CLK_GAIN_A;
        `SLOT_GAIN_B: mask_of = `MASK_GAIN_B;
        `SLOT_REF_FILTER: mask_of = `MASK_REF_FILTER;
        `SLOT_POWER_DOWN: mask_of = `MASK_POWER_DOWN;
        `SLOT_NOVIDEO: mask_of = `MASK_NOVIDEO;
        `SLOT_CLAMP_TEST: mask_of = `MASK_CLAMP_TEST;
        default: mask_of = `MASK_FULL;
      endcase
    end
  endfunction : mask_of

  // Reset value of each slot.
  function automatic video_common_pkg::byte_type reset_of(
    input video_common_pkg::slot_type slot
  );
    begin
      case (slot)
        `SLOT_CLK_GAIN_A: reset_of = `RST_CLK_GAIN_A;
        `SLOT_GAIN_B: reset_of = `RST_GAIN_B;
        `SLOT_SYNC_CTRL: reset_of = `RST_SYNC_CTRL;
        `SLOT_GAIN_LOOP: reset_of = `RST_GAIN_LOOP;
        `SLOT_MGAIN_CH1: reset_of = `RST_MGAIN_LOW;
        5'h05: reset_of = `RST_MGAIN_LOW;
        5'h06: reset_of = `RST_MGAIN_LOW;
        5'h07: reset_of = `RST_MGAIN_LOW;
        `SLOT_REF_FILTER: reset_of = `RST_REF_FILTER;
        `SLOT_POWER_DOWN: reset_of = `RST_POWER_DOWN;
        `SLOT_NOVIDEO: reset_of = `RST_NOVIDEO;
        `SLOT_FREERUN: reset_of = `RST_FREERUN;
        `SLOT_CORING_SW: reset_of = `RST_CORING_SW;
        default: reset_of = `RST_ZERO;
      endcase
    end
  endfunction : reset_of

  // --------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------
  video_common_pkg::byte_type regs_reg [`NUM_SLOTS];
  video_common_pkg::slot_type wr_slot;
  video_common_pkg::byte_type status_reg;
  video_common_pkg::byte_type rdata_next;

  assign wr_slot = slot_of(reg_addr);

  // Writes land under the slot's mask; the status offset maps to no
  // slot, so a write there changes nothing.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `NUM_SLOTS; i = i + 1) begin
        regs_reg[i] <= reset_of(5'(i));
      end
    end else if (reg_wr && wr_slot != `SLOT_NONE) begin
      regs_reg[wr_slot] <= reg_wdata & mask_of(wr_slot);
    end
  end

  // --------------------------------------------------------------
  // Status capture
  // --------------------------------------------------------------

  // Field flags are reported in the sense chosen for the field
  // output, so software sees the same level as the pin.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= 8'h00;
    end else begin
      status_reg[7:4] <= ch_odd_field ^
        {4{regs_reg[`SLOT_SYNC_CTRL][`BIT_FIELD_POL]}};
      status_reg[3:0] <= ch_vactive;
    end
  end

  // --------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------

  // Read data select; unmapped offsets read as zero.
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == `OFS_STATUS) begin
      rdata_next = status_reg;
    end else if (wr_slot != `SLOT_NONE) begin
      rdata_next = regs_reg[wr_slot];
    end
  end

  // Data stand only in the cycle after the read strobe.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // Analog output clock and gain controls
  // --------------------------------------------------------------

  // The enable gates both pixel clock pins together.
  assign pixclk_out_enable =
    regs_reg[`SLOT_CLK_GAIN_A][`BIT_PIXCLK_OE];
  // Code n gives 90.625 + 3.125 * n percent.
  assign dac_output_gain_cx = regs_reg[`SLOT_CLK_GAIN_A][6:4];
  assign dac_output_gain_yx = regs_reg[`SLOT_CLK_GAIN_A][2:0];
  assign dac_output_gain_yy = regs_reg[`SLOT_GAIN_B][2:0];

  // --------------------------------------------------------------
  // Sync outputs
  // --------------------------------------------------------------

  // Polarity and timing source come straight from the sync control.
  sync_out_shaper u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .vsync_align_sel(regs_reg[`SLOT_SYNC_CTRL][`BIT_VS_ALIGN]),
    .field_flag_polarity(regs_reg[`SLOT_SYNC_CTRL][`BIT_FIELD_POL]),
    .hsync_out_polarity(regs_reg[`SLOT_SYNC_CTRL][`BIT_HS_POL]),
    .vsync_out_polarity(regs_reg[`SLOT_SYNC_CTRL][`BIT_VS_POL]),
    .hs_in(hs_in),
    .vs_in(vs_in),
    .odd_field_in(odd_field_in),
    .hsync_out(hsync_out),
    .vsync_out(vsync_out),
    .field_flag_out(field_flag_out)
  );

  // --------------------------------------------------------------
  // Gain loop and manual gain
  // --------------------------------------------------------------

  // The ninth gain bit of each channel lives in the shared register.
  assign auto_gain_loop_off = regs_reg[`SLOT_GAIN_LOOP][7:4];
  assign manual_gain_value = {
    regs_reg[`SLOT_GAIN_LOOP][3], regs_reg[5'h07],
    regs_reg[`SLOT_GAIN_LOOP][2], regs_reg[5'h06],
    regs_reg[`SLOT_GAIN_LOOP][1], regs_reg[5'h05],
    regs_reg[`SLOT_GAIN_LOOP][0], regs_reg[`SLOT_MGAIN_CH1]
  };

  // Gain applied per channel; registered, so a write to a low byte or
  // the shared top bit reaches the analog side one cycle later.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      applied_gain <= 36'h000000000;
    end else begin
      for (int i = 0; i < 4; i = i + 1) begin
        if (auto_gain_loop_off[i]) begin
          applied_gain[i*9 +: 9] <= manual_gain_value[i*9 +: 9];
        end else begin
          applied_gain[i*9 +: 9] <= auto_gain_in[i*9 +: 9];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Converter references, filters and power-down
  // --------------------------------------------------------------

  // One filter enable and one power mode cover all four channels.
  assign adc_current_ref_boost = regs_reg[`SLOT_REF_FILTER][`BIT_ADC_ADC_CURRENT_REF_BOOST];
  assign video_vref_shutdown = regs_reg[`SLOT_REF_FILTER][`BIT_ADC_VREF];
  assign video_antialias_en =
    regs_reg[`SLOT_REF_FILTER][`BIT_ANTIALIAS];
  assign video_reduced_power =
    regs_reg[`SLOT_REF_FILTER][`BIT_REDUCED_PWR];
  assign audio_dac_powerdown =
    regs_reg[`SLOT_POWER_DOWN][`BIT_AUDIO_DAC_POWERDOWN];
  assign audio_adc_powerdown =
    regs_reg[`SLOT_POWER_DOWN][`BIT_AUDIO_ADC_POWERDOWN];
  // Bit n powers down channel n.
  assign video_adc_powerdown = regs_reg[`SLOT_POWER_DOWN][3:0];

  // --------------------------------------------------------------
  // Decoder mode fields
  // --------------------------------------------------------------

  // Code 1 of the free-run field has no meaning; it is passed on as
  // written because the decoder core owns its interpretation.
  assign novideo_flag_speed = regs_reg[`SLOT_NOVIDEO][3:2];
  assign freerun_rate = regs_reg[`SLOT_FREERUN][7:6];
  assign luma_noise_reduction = regs_reg[`SLOT_FREERUN][5:4];
  // Clamp code 3 is not to be used; it is held as written.
  assign clamp_mode = regs_reg[`SLOT_FREERUN][3:2];
  assign slice_level = regs_reg[`SLOT_FREERUN][1:0];
  assign peaking_test_field = {
    regs_reg[`SLOT_PEAK_CH34], regs_reg[`SLOT_PEAK_CH12]
  };

  // --------------------------------------------------------------
  // Clamp and test controls
  // --------------------------------------------------------------

  // Test controls default to zero and are only passed through.
  assign clamp_debug = regs_reg[`SLOT_CLAMP_TEST][`BIT_CLAMP_DEBUG];
  assign luma_clamp_off =
    regs_reg[`SLOT_CLAMP_TEST][`BIT_LUMA_CLAMP_OFF];
  assign audio_antialias_en =
    regs_reg[`SLOT_CLAMP_TEST][`BIT_AUDIO_AA];
  assign gain_test = regs_reg[`SLOT_CLAMP_TEST][`BIT_GAIN_TEST];
  assign clamp_filter_ctrl =
    regs_reg[`SLOT_CLAMP_TEST][`BIT_CLAMP_FILTER];
  assign clamp_current_one = regs_reg[`SLOT_CLAMP_TEST][`BIT_CLAMP_CUR1];
  assign clamp_current_two = regs_reg[`SLOT_CLAMP_TEST][`BIT_CLAMP_CUR2];
  assign analog_channel_test = regs_reg[`SLOT_ANA_TEST];

  // --------------------------------------------------------------
  // Coring and input selection
  // --------------------------------------------------------------

  // Bit n selects input B for channel n.
  assign sharpness_coring = regs_reg[`SLOT_CORING_SW][7:4];
  assign input_a_b_select = regs_reg[`SLOT_CORING_SW][3:0];

endmodule : video_decoder_common_ctrl_regs

/* File: testbench/video_ctrl_asserts.sv */
/*
  Port-level checker of the common video control registers.
  Assumes it is bound into the top module and sees only its ports.
*/
`timescale 1ns/10ps
`include "video_common_defs.svh"
module video_ctrl_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pixclk_out_enable,
  input wire logic hs_in,
  input wire logic hsync_out,
  input wire logic [3:0] auto_gain_loop_off,
  input wire logic [35:0] manual_gain_value,
  input wire logic [35:0] auto_gain_in,
  input wire logic [35:0] applied_gain,
  input wire logic audio_dac_powerdown,
  input wire logic audio_adc_powerdown,
  input wire logic [3:0] video_adc_powerdown,
  input wire logic [1:0] freerun_rate,
  input wire logic [1:0] luma_noise_reduction,
  input wire logic [1:0] clamp_mode,
  input wire logic [1:0] slice_level,
  input wire logic [3:0] sharpness_coring,
  input wire logic [3:0] input_a_b_select,
  input wire logic [3:0] ch_vactive
);
  // ------------------------------------------------------------
  // Expected gain selection
  // ------------------------------------------------------------
  logic [35:0] gain_mux;

  // A channel takes its manual gain only while its loop is off.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gain_mux[9*i +: 9] = auto_gain_loop_off[i] ?
        manual_gain_value[9*i +: 9] : auto_gain_in[9*i +: 9];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_coring_wr;
    reg_wr && reg_addr == `OFS_CORING_SW;
  endsequence
  sequence s_coring_rd;
    reg_rd && reg_addr == `OFS_CORING_SW;
  endsequence

  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  AST_CORING_BACK: assert property (
    s_coring_wr ##2 s_coring_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("coring readback wrong");
  AST_CORING_OUT: assert property (
    s_coring_wr |=> {sharpness_coring, input_a_b_select} == $past(reg_wdata))
    else $error("coring or switch output wrong");
  AST_HSYNC_EDGE: assert property (
    $changed(hs_in) && !reg_wr && !$past(reg_wr) |=> $changed(hsync_out))
    else $error("hsync output did not follow input");
  AST_GAIN_MUX: assert property (
    1'b1 |=> applied_gain == $past(gain_mux)) else $error("gain mux wrong");
  AST_LOOP_OFF: assert property (
    reg_wr && reg_addr == `OFS_GAIN_LOOP |=> auto_gain_loop_off ==
    $past(reg_wdata[7:4]) && manual_gain_value[8] == $past(reg_wdata[0]))
    else $error("gain loop write wrong");
  AST_PIXCLK: assert property (
    reg_wr && reg_addr == `OFS_CLK_GAIN_A |=>
    pixclk_out_enable == $past(reg_wdata[7])) else $error("pixclk wrong");
  AST_PWRDN: assert property (
    reg_wr && reg_addr == `OFS_POWER_DOWN |=> {audio_dac_powerdown,
    audio_adc_powerdown, video_adc_powerdown} == $past(reg_wdata[5:0]))
    else $error("power down write wrong");
  AST_FREERUN: assert property (
    reg_wr && reg_addr == `OFS_FREERUN |=> {freerun_rate,
    luma_noise_reduction, clamp_mode, slice_level} == $past(reg_wdata))
    else $error("free-run register write wrong");
  AST_STATUS_VACT: assert property (
    reg_rd && reg_addr == `OFS_STATUS |=>
    reg_rdata[3:0] == $past(ch_vactive, 2)) else $error("status wrong");
  AST_STATUS_RO: assert property (
    reg_wr && reg_addr == `OFS_STATUS |=> $stable({auto_gain_loop_off,
    sharpness_coring, video_adc_powerdown})) else $error("status written");
endmodule : video_ctrl_asserts

bind video_decoder_common_ctrl_regs video_ctrl_asserts u_chk (
  .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .pixclk_out_enable, .hs_in, .hsync_out, .auto_gain_loop_off,
  .manual_gain_value, .auto_gain_in, .applied_gain, .audio_dac_powerdown,
  .audio_adc_powerdown, .video_adc_powerdown, .freerun_rate,
  .luma_noise_reduction, .clamp_mode, .slice_level, .sharpness_coring,
  .input_a_b_select, .ch_vactive
);

/* File: testbench/video_decoder_common_ctrl_regs_bench.sv */
/*
  Self-checking bench of the common video control registers.
  Assumes the design and the checker are compiled before it.
*/
`timescale 1ns/10ps
module video_decoder_common_ctrl_regs_bench;
  logic core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic hs_in = 1'b0, vs_in = 1'b0, odd_field_in = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [35:0] auto_gain_in = 36'h0, manual_gain_value, applied_gain;
  logic [3:0] ch_odd_field = 4'h0, ch_vactive = 4'h0, auto_gain_loop_off;
  logic [2:0] dac_output_gain_cx, dac_output_gain_yx, dac_output_gain_yy;
  logic pixclk_out_enable, hsync_out, vsync_out, field_flag_out;
  logic video_antialias_en, video_reduced_power, audio_antialias_en;
  logic [1:0] novideo_flag_speed;
  logic [3:0] sharpness_coring, input_a_b_select;
  int fail_count = 0, checks = 0;
  logic [7:0] ofs [17] = '{8'h41, 8'h42, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49,
    8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h56, 8'h57};
  logic [7:0] rst [17] = '{8'h77, 8'h07, 8'hd1, 8'h00, 8'hf0, 8'hf0, 8'hf0,
    8'hf0, 8'h02, 8'h00, 8'h0f, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30};
  logic [7:0] msk [17] = '{8'hf7, 8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h63, 8'h3f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hdf, 8'hff, 8'hff};

  video_decoder_common_ctrl_regs dut (.core_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pixclk_out_enable,
    .dac_output_gain_cx, .dac_output_gain_yx, .dac_output_gain_yy, .hs_in,
    .vs_in, .odd_field_in, .hsync_out, .vsync_out, .field_flag_out,
    .auto_gain_loop_off, .manual_gain_value, .auto_gain_in, .applied_gain,
    .adc_current_ref_boost(), .video_vref_shutdown(), .video_antialias_en,
    .video_reduced_power, .audio_dac_powerdown(), .audio_adc_powerdown(),
    .video_adc_powerdown(), .novideo_flag_speed, .freerun_rate(),
    .luma_noise_reduction(), .clamp_mode(), .slice_level(),
    .peaking_test_field(), .clamp_debug(), .luma_clamp_off(),
    .audio_antialias_en, .gain_test(), .clamp_filter_ctrl(),
    .clamp_current_one(), .clamp_current_two(), .analog_channel_test(),
    .sharpness_coring, .input_a_b_select, .ch_odd_field, .ch_vactive);

  // Free-running core clock at 25 MHz.
  always #20 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [35:0] exp, got);
    checks++;
    if (exp !== got) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Both bus tasks start and end just after a rising edge.
  task automatic wr(input logic [7:0] a, d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    @(posedge core_clk);
  endtask : rd

  function automatic logic [35:0] gain_exp(input logic [3:0] off,
    input logic [35:0] man, au);
    for (int i = 0; i < 4; i++) begin
      gain_exp[9*i +: 9] = off[i] ? man[9*i +: 9] : au[9*i +: 9];
    end
  endfunction : gain_exp

  // Cuts a hung run short; counts as a mismatch.
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d, w;
    logic [3:0] off;
    logic [35:0] man;
    void'($urandom(76));
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk("pixclk", 36'h0, pixclk_out_enable);
    chk("vgain", 36'h1ff, {dac_output_gain_cx, dac_output_gain_yx,
      dac_output_gain_yy});
    chk("filt", 36'h2, {video_antialias_en, video_reduced_power});
    for (int i = 0; i < 17; i++) begin
      rd(ofs[i], d);
      chk("reset", rst[i], d);
    end
    // Random readback, masked bits read zero.
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 17; i++) begin
        w = 8'($urandom);
        wr(ofs[i], w);
        rd(ofs[i], d);
        chk("rw", w & msk[i], d);
      end
    end
    wr(8'h4e, 8'hff);
    rd(8'h4e, d);
    chk("unmapped", 36'h0, d);
    for (int c = 0; c < 4; c++) begin
      wr(8'h4f, {4{2'(c)}});
      wr(8'h4d, {4'h0, 2'(c), 2'b11});
      chk("novid", 36'(c), novideo_flag_speed);
    end
    wr(8'h52, 8'h10);
    wr(8'h4b, 8'h01);
    wr(8'h41, 8'h80);
    chk("vgain", 36'h0, {dac_output_gain_cx, dac_output_gain_yx});
    chk("afilt", 36'h1, audio_antialias_en);
    chk("filt", 36'h1, {video_antialias_en, video_reduced_power});
    chk("pixclk", 36'h1, pixclk_out_enable);
    // Manual gain with every loop off, none off, then random patterns.
    for (int r = 0; r < 4; r++) begin
      off = (r == 0) ? 4'hf : (r == 1) ? 4'h0 : 4'($urandom);
      man = 36'({$urandom, $urandom});
      auto_gain_in <= 36'({$urandom, $urandom});
      wr(8'h46, {off, man[35], man[26], man[17], man[8]});
      for (int c = 0; c < 4; c++) begin
        wr(8'(8'h47 + c), man[9*c +: 8]);
      end
      repeat (2) @(posedge core_clk);
      chk("mgain", man, manual_gain_value);
      chk("again", gain_exp(off, man, auto_gain_in), applied_gain);
    end
    // Every polarity setting with random sync and status inputs.
    for (int p = 0; p < 8; p++) begin
      wr(8'h45, {3'b110, 3'(p), 2'b01});
      wr(8'h55, 8'($urandom));
      for (int k = 0; k < 6; k++) begin
        hs_in <= 1'($urandom);
        vs_in <= 1'($urandom);
        odd_field_in <= 1'($urandom);
        ch_odd_field <= 4'($urandom);
        ch_vactive <= 4'($urandom);
        @(posedge core_clk);
        @(negedge core_clk);
        chk("hs", hs_in ? p[1] : !p[1], hsync_out);
        chk("vs", vs_in ? p[0] : !p[0], vsync_out);
        chk("fld", odd_field_in ^ p[2], field_flag_out);
        @(posedge core_clk);
        rd(8'h55, d);
        chk("stat", {ch_odd_field ^ {4{p[2]}}, ch_vactive}, d);
      end
    end
    // Vertical sync taken only where horizontal sync rises.
    wr(8'h45, 8'hf5);
    hs_in <= 1'b0;
    vs_in <= 1'b0;
    @(posedge core_clk);
    hs_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("vsal", 36'h0, vsync_out);
    vs_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("vsal", 36'h0, vsync_out);
    hs_in <= 1'b0;
    @(posedge core_clk);
    hs_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("vsal", 36'h1, vsync_out);
    report_and_stop();
  end
endmodule : video_decoder_common_ctrl_regs_bench
